//--- verilog/tvdac_pkg.sv
package tvdac_pkg;

	// per-channel level selection, one-hot
	typedef enum logic [4:0] {
		TVDAC_LVL_DATA = 5'b00001,
		TVDAC_LVL_BLACK = 5'b00010,
		TVDAC_LVL_BLANK = 5'b00100,
		TVDAC_LVL_OVER = 5'b01000,
		TVDAC_LVL_SYNC = 5'b10000
	} tvdac_level_t;

	localparam int TVDAC_WORD_W = 8;
	localparam int TVDAC_FIFO_DEPTH = 8;
	localparam int TVDAC_FIFO_AW = 3;
	localparam int TVDAC_SEG_W = 16;

	// register map, byte addresses
	localparam logic [7:0] TVDAC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TVDAC_OFS_STAT = 8'h04;
	localparam logic [7:0] TVDAC_OFS_LEVEL = 8'h08;
	localparam logic [7:0] TVDAC_OFS_CODE = 8'h0c;

	localparam int TVDAC_CTRL_EN_BIT = 0;
	localparam int TVDAC_CTRL_BYP_BIT = 1;
	localparam logic [1:0] TVDAC_CTRL_RST = 2'h1;
	localparam logic [TVDAC_WORD_W-1:0] TVDAC_FULL_CODE = 8'hff;
	localparam logic [TVDAC_WORD_W-1:0] TVDAC_ZERO_CODE = 8'h00;

	// one pixel with its video controls
	typedef struct packed {
		logic sync;
		logic blank;
		logic overlay;
		logic [TVDAC_WORD_W-1:0] green;
		logic [TVDAC_WORD_W-1:0] red;
		logic [TVDAC_WORD_W-1:0] blue;
	} tvdac_pixel_t;

	localparam int TVDAC_PIX_W = $bits(tvdac_pixel_t);

	// drive to one complementary current pair
	typedef struct packed {
		tvdac_level_t level;
		logic [TVDAC_SEG_W-1:0] seg;
		logic [TVDAC_WORD_W-1:0] minus_code;
		logic [TVDAC_WORD_W-1:0] plus_code;
	} tvdac_chan_t;

endpackage

//--- verilog/tvdac_mem.sv
`timescale 1ns/10ps
`default_nettype none
module tvdac_mem
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
)
(
	// clock
	input wire logic mclk,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read side, registered
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge mclk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule
`default_nettype wire

//--- verilog/tvdac_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module tvdac_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic ov;
	} tvdac_fifo_st_t;

	tvdac_fifo_st_t st_q, st_d;
	logic [AW:0] count;
	logic push, pop, rd_take;
	logic [WIDTH-1:0] rd_data;

	assign count = st_q.wp - st_q.rp;
	// the word held in the output stage still owns its memory slot, so it counts toward depth
	assign in_ready = st_q.ov ? (count != (AW+1)'(DEPTH - 1)) : (count != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign out_valid = st_q.ov;
	assign pop = st_q.ov && out_ready;
	// fetch next word when output stage is free or being drained
	assign rd_take = (st_q.wp != st_q.rp) && (!st_q.ov || pop);
	assign out_data = rd_data;

	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.wp = st_q.wp + 1'b1;
		end
		if (rd_take)
		begin
			st_d.rp = st_q.rp + 1'b1;
			st_d.ov = 1'b1;
		end
		else if (pop)
		begin
			st_d.ov = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// read data register holds the head word while out_valid stands
	tvdac_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.mclk(mclk),
		.wr_en(push),
		.wr_addr(st_q.wp[AW-1:0]),
		.wr_data(in_data),
		.rd_addr(rd_take ? st_q.rp[AW-1:0] : st_q.rp[AW-1:0] - 1'b1),
		.rd_data(rd_data)
	);

endmodule
`default_nettype wire

//--- verilog/tvdac_top.sv
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tvdac_top
	import tvdac_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// pixel input stream from the display controller
	input wire logic pix_valid,
	output logic pix_ready,
	input wire logic [TVDAC_WORD_W-1:0] green_word,
	input wire logic [TVDAC_WORD_W-1:0] red_word,
	input wire logic [TVDAC_WORD_W-1:0] blue_word,
	input wire logic video_sync,
	input wire logic video_blank,
	input wire logic video_overlay,
	// current switch drive
	output tvdac_chan_t green_out,
	output tvdac_chan_t red_out,
	output tvdac_chan_t blue_out,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// thermometer decode of the upper four bits, weights the segmented switches
	function automatic logic [TVDAC_SEG_W-1:0] seg_decode(input logic [TVDAC_WORD_W-1:0] w);
		logic [TVDAC_SEG_W-1:0] t;
		t = '0;
		for (int i = 0; i < TVDAC_SEG_W; i++)
		begin
			t[i] = (5'(i) < {1'b0, w[7:4]});
		end
		return t;
	endfunction

	// bus bit position 7 is the word's most significant pin
	function automatic logic [TVDAC_WORD_W-1:0] word_in(input logic [TVDAC_WORD_W-1:0] w, input logic en);
		return en ? w : TVDAC_ZERO_CODE;
	endfunction

	// level choice by priority: sync, blank, overlay, data
	function automatic tvdac_chan_t chan_sel(input tvdac_pixel_t p,
		input logic [TVDAC_WORD_W-1:0] w, input logic is_green);
		tvdac_chan_t c;
		c.seg = seg_decode(w);
		if (p.sync)
		begin
			c.level = is_green ? TVDAC_LVL_SYNC : TVDAC_LVL_BLANK;
		end
		else if (p.blank)
		begin
			c.level = TVDAC_LVL_BLANK;
		end
		else if (p.overlay)
		begin
			c.level = TVDAC_LVL_OVER;
		end
		else if (w == TVDAC_ZERO_CODE)
		begin
			c.level = TVDAC_LVL_BLACK;
		end
		else
		begin
			c.level = TVDAC_LVL_DATA;
		end
		case (c.level)
			TVDAC_LVL_SYNC:
			begin
				c.minus_code = TVDAC_FULL_CODE;
				c.plus_code = TVDAC_ZERO_CODE;
			end
			TVDAC_LVL_BLANK:
			begin
				c.minus_code = TVDAC_FULL_CODE;
				c.plus_code = TVDAC_ZERO_CODE;
			end
			TVDAC_LVL_OVER:
			begin
				c.minus_code = TVDAC_ZERO_CODE;
				c.plus_code = TVDAC_FULL_CODE;
			end
			TVDAC_LVL_BLACK, TVDAC_LVL_DATA:
			begin
				// minus current shrinks as code rises
				c.minus_code = ~w;
				c.plus_code = w;
			end
			default:
			begin
				c.minus_code = TVDAC_ZERO_CODE;
				c.plus_code = TVDAC_ZERO_CODE;
			end
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// input capture

	typedef struct packed {
		tvdac_pixel_t pix;
		logic [1:0] ctrl;
		tvdac_chan_t g;
		tvdac_chan_t r;
		tvdac_chan_t b;
		logic [31:0] frames;
		logic [7:0] ap_addr;
		logic ap_wr;
		logic ap_rd;
	} tvdac_state_t;

	tvdac_state_t st_q, st_d;
	tvdac_pixel_t in_pix;
	tvdac_pixel_t q_pix;
	logic q_valid, q_ready;
	logic enable, bypass;
	logic take;

	assign enable = st_q.ctrl[TVDAC_CTRL_EN_BIT];
	assign bypass = st_q.ctrl[TVDAC_CTRL_BYP_BIT];

	always_comb
	begin
		// undriven pins are assumed pulled low by the pad ring
		in_pix.sync = video_sync;
		in_pix.blank = video_blank;
		in_pix.overlay = video_overlay;
		in_pix.green = word_in(green_word, 1'b1);
		in_pix.red = word_in(red_word, 1'b1);
		in_pix.blue = word_in(blue_word, 1'b1);
	end

	// pixel buffer; while disabled the drain stalls and the fifo fills
	tvdac_fifo #(.WIDTH(TVDAC_PIX_W), .DEPTH(TVDAC_FIFO_DEPTH), .AW(TVDAC_FIFO_AW)) u_fifo (
		.mclk(mclk),
		.resetn(resetn),
		.in_valid(pix_valid),
		.in_ready(pix_ready),
		.in_data(in_pix),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_pix)
	);

	assign q_ready = enable;
	assign take = q_valid && q_ready;

	////////////////////////////////////////////////////////////////////////////////
	// bus access

	logic ap_valid;
	logic [31:0] rd_word;

	assign ap_valid = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb
	begin
		rd_word = '0;
		case (st_q.ap_addr)
			TVDAC_OFS_CTRL: rd_word = {30'h0, st_q.ctrl};
			TVDAC_OFS_STAT: rd_word = st_q.frames;
			TVDAC_OFS_LEVEL: rd_word = {17'h0, st_q.g.level, st_q.r.level, st_q.b.level};
			TVDAC_OFS_CODE: rd_word = {8'h0, st_q.g.plus_code, st_q.r.plus_code, st_q.b.plus_code};
			default: rd_word = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		st_d = st_q;
		st_d.ap_wr = ap_valid && hwrite;
		st_d.ap_rd = ap_valid && !hwrite;
		if (ap_valid)
		begin
			st_d.ap_addr = haddr[7:0];
		end
		if (st_q.ap_wr && st_q.ap_addr == TVDAC_OFS_CTRL)
		begin
			st_d.ctrl = hwdata[1:0];
		end
		if (take)
		begin
			// controls and words sampled together on the same edge
			st_d.pix = bypass ? in_pix : q_pix;
			st_d.frames = st_q.frames + 32'h1;
		end
		// selection registered from the sampled pixel, one edge later
		st_d.g = chan_sel(st_q.pix, st_q.pix.green, 1'b1);
		st_d.r = chan_sel(st_q.pix, st_q.pix.red, 1'b0);
		st_d.b = chan_sel(st_q.pix, st_q.pix.blue, 1'b0);
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= '0;
			st_q.ctrl <= TVDAC_CTRL_RST;
			st_q.pix.blank <= 1'b1;
			st_q.g.level <= TVDAC_LVL_BLANK;
			st_q.r.level <= TVDAC_LVL_BLANK;
			st_q.b.level <= TVDAC_LVL_BLANK;
			st_q.g.minus_code <= TVDAC_FULL_CODE;
			st_q.r.minus_code <= TVDAC_FULL_CODE;
			st_q.b.minus_code <= TVDAC_FULL_CODE;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// all three channels update on the same edge
	assign green_out = st_q.g;
	assign red_out = st_q.r;
	assign blue_out = st_q.b;
	assign hrdata = st_q.ap_rd ? rd_word : 32'h0;

endmodule
`default_nettype wire

//--- tb/tvdac_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tvdac_top_sva
	import tvdac_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// channel drive
	input wire tvdac_chan_t green_out,
	input wire tvdac_chan_t red_out,
	input wire tvdac_chan_t blue_out,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	logic rd_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////
	// marks the data phase of a read
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rd_q <= 1'b0;
		else
			rd_q <= hsel && hready && htrans[1] && !hwrite;
	end
	////////////////////////////////////////////////////////////
	chk_reset_blank: assert property ($rose(resetn) |->
		green_out.level == TVDAC_LVL_BLANK && blue_out.level == TVDAC_LVL_BLANK) else $error("not blank");
	chk_sync_green: assert property (green_out.level == TVDAC_LVL_SYNC |->
		green_out.minus_code == 8'hff && green_out.plus_code == 8'h00) else $error("sync drive");
	chk_sync_side: assert property (green_out.level == TVDAC_LVL_SYNC |->
		red_out.level == TVDAC_LVL_BLANK && blue_out.level == TVDAC_LVL_BLANK) else $error("sync side");
	chk_blank_all: assert property (green_out.level == TVDAC_LVL_BLANK |->
		red_out.level == TVDAC_LVL_BLANK && green_out.minus_code == 8'hff) else $error("blank");
	chk_over_all: assert property (green_out.level == TVDAC_LVL_OVER |->
		blue_out.level == TVDAC_LVL_OVER && red_out.plus_code == 8'hff) else $error("overlay");
	chk_black_code: assert property (blue_out.level == TVDAC_LVL_BLACK |->
		blue_out.plus_code == 8'h00 && blue_out.minus_code == 8'hff) else $error("black");
	chk_data_comp: assert property (red_out.level == TVDAC_LVL_DATA |->
		red_out.minus_code == ~red_out.plus_code && red_out.plus_code != 8'h00) else $error("data pair");
	chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus response");
	chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data idle");
endmodule
bind tvdac_top tvdac_top_sva u_sva (.mclk(mclk), .resetn(resetn), .green_out(green_out),
	.red_out(red_out), .blue_out(blue_out), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

//--- tb/tvdac_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module tvdac_host_model
	import tvdac_pkg::*;
(
	// clock
	input wire logic mclk,
	// pixel stream
	input wire logic pix_ready,
	output var logic pix_valid,
	output var tvdac_pixel_t pix
);
	initial
	begin
		pix_valid = 1'b0;
		pix = '0;
	end
	// offer a pixel right after a rising edge, hold it until taken
	task automatic send(input tvdac_pixel_t p);
		pix <= p;
		pix_valid <= 1'b1;
		do
			@(negedge mclk);
		while (pix_ready !== 1'b1);
		@(posedge mclk);
	endtask
	// released lines fall to their pull-down level
	task automatic idle();
		pix <= '0;
		pix_valid <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb/triple_video_dac_input_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module triple_video_dac_input_control_tb
	import tvdac_pkg::*;
;
	logic mclk, resetn, pix_valid, pix_ready, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	tvdac_pixel_t pix;
	tvdac_chan_t green_out, red_out, blue_out;
	int errors, compares;
	tvdac_host_model u_host (.mclk(mclk), .pix_ready(pix_ready), .pix_valid(pix_valid), .pix(pix));
	tvdac_top u_dut (.mclk(mclk), .resetn(resetn), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.green_word(pix.green), .red_word(pix.red), .blue_word(pix.blue), .video_sync(pix.sync),
		.video_blank(pix.blank), .video_overlay(pix.overlay), .green_out(green_out),
		.red_out(red_out), .blue_out(blue_out), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// single word transfer, read data taken in the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do
			@(negedge mclk);
		while (hreadyout !== 1'b1);
		@(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do
		begin
			@(negedge mclk);
			rd = hrdata;
		end
		while (hreadyout !== 1'b1);
		@(posedge mclk);
	endtask
	function automatic logic [20:0] exp_ch(input tvdac_pixel_t p, input int c);
		logic [7:0] w;
		w = (c == 0) ? p.green : (c == 1) ? p.red : p.blue;
		if (p.sync)
			return {(c == 0) ? TVDAC_LVL_SYNC : TVDAC_LVL_BLANK, 16'hff00};
		if (p.blank)
			return {TVDAC_LVL_BLANK, 16'hff00};
		if (p.overlay)
			return {TVDAC_LVL_OVER, 16'h00ff};
		return {(w == 8'h00) ? TVDAC_LVL_BLACK : TVDAC_LVL_DATA, ~w, w};
	endfunction
	task automatic chk(input tvdac_pixel_t p);
		cmp({green_out.level, green_out.minus_code, green_out.plus_code}, exp_ch(p, 0));
		cmp({red_out.level, red_out.minus_code, red_out.plus_code}, exp_ch(p, 1));
		cmp({blue_out.level, blue_out.minus_code, blue_out.plus_code}, exp_ch(p, 2));
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		ahb(1'b0, TVDAC_OFS_CTRL, 32'h0);
		cmp(rd, 32'h1);
		chk(27'h2000000);
	endtask
	// every control priority, then plain codes; old level must stand through edge three, new one after edge four
	task automatic t_codes();
		tvdac_pixel_t tbl[6];
		tvdac_pixel_t prev;
		tbl = '{27'h7aabbcc, 27'h3aabbcc, 27'h1aabbcc, 27'h0ffffff, 27'h0000000, 27'h0813c01};
		prev = 27'h2000000;
		foreach (tbl[i])
		begin
			u_host.send(tbl[i]);
			u_host.idle();
			repeat (3) @(negedge mclk);
			chk(prev);
			@(negedge mclk);
			chk(tbl[i]);
			prev = tbl[i];
			@(posedge mclk);
		end
	endtask
	// fill with drain stopped until refused, then drain in order
	task automatic t_fifo();
		logic [7:0] seen[$];
		logic [7:0] lastg;
		ahb(1'b1, TVDAC_OFS_CTRL, 32'h0);
		for (int i = 0; i < 8; i++)
			u_host.send({3'b000, 8'h10 + 8'(i), 8'h20 + 8'(i), 8'h30 + 8'(i)});
		@(negedge mclk);
		cmp(pix_ready, 1'b0);
		chk(27'h0813c01);
		@(posedge mclk);
		u_host.idle();
		ahb(1'b1, TVDAC_OFS_CTRL, 32'h1);
		lastg = 8'h81;
		repeat (20)
		begin
			@(negedge mclk);
			if (green_out.plus_code !== lastg)
				seen.push_back(green_out.plus_code);
			lastg = green_out.plus_code;
		end
		cmp(seen.size(), 8);
		foreach (seen[i])
			cmp(seen[i], 8'h10 + i);
		chk(27'h0172737);
		cmp(green_out.seg, 32'h0001);
		cmp(red_out.seg, 32'h0003);
		cmp(blue_out.seg, 32'h0007);
		cmp(pix_ready, 1'b1);
		@(posedge mclk);
	endtask
	task automatic t_regs();
		ahb(1'b0, TVDAC_OFS_CODE, 32'h0);
		cmp(rd, 32'h00172737);
		ahb(1'b0, TVDAC_OFS_LEVEL, 32'h0);
		cmp(rd, 32'h0421);
		ahb(1'b1, TVDAC_OFS_CODE, 32'h0);
		ahb(1'b0, TVDAC_OFS_CODE, 32'h0);
		cmp(rd, 32'h00172737);
		ahb(1'b0, TVDAC_OFS_STAT, 32'h0);
		cmp(rd, 32'he);
		ahb(1'b1, 8'h10, 32'hffffffff);
		ahb(1'b0, 8'h10, 32'h0);
		cmp(rd, 32'h0);
		ahb(1'b0, TVDAC_OFS_CTRL, 32'h0);
		cmp(rd, 32'h1);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		errors = 0;
		compares = 0;
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = '0;
		hwrite = 1'b0;
		hsize = '0;
		hwdata = '0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_codes();
		t_fifo();
		t_regs();
		end_of_test();
	end
	initial
	begin
		#100000;
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
